// ===== stp_device.sv
// Contract
// [R1] master keeps data steady while clock high
// [R2] data fall with clock high starts transfer
// [R3] data rise with clock high ends transfer
// [R4] bytes MSB first, then one acknowledge slot
// [R5] addressed device pulls data low on ninth pulse
// [R6] master releases data line during acknowledge pulse
// [R7] missing acknowledge lets master stop and abort
// [R8] master may skip acknowledge check, clock on
// [R9] start, address 1100000 write, two bytes, stop
// [R10] data byte MSB selects destination of seven bits
// [R11] single data byte transfer also accepted
// [R12] select one loads synthesizer channel setting
// [R13] select zero loads test and lock mode
// [R14] ratio is 1440 plus half the channel code
// [R15] lock test modes drive lock indicator, default first
// [R16] divider test modes output divided divider signal; the IF reference mode passes its tick through undivided
// [R17] foreign address ignored until next start
// [R18] setting updates only after full eight bits
`timescale 1ns/1ps
module stp_device (
  input wire logic core_clk,
  input wire logic rst,
  stp_if.device link,
  input wire logic rf_lock,
  input wire logic if_lock,
  input wire logic rf_prog_div_tick,
  input wire logic rf_ref_div_tick,
  input wire logic if_fix_div_tick,
  input wire logic if_ref_div_tick,
  output logic [6:0] channel_word,
  output logic [6:0] mode_word,
  output logic [11:0] rf_ratio_x2,
  output logic [10:0] if_ratio,
  output logic channel_load,
  output logic mode_load,
  output logic lock_indicator_output
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DATA = 5'b00100,
    ST_ACK = 5'b01000,
    ST_IGNORE = 5'b10000
  } stp_state_t;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  stp_state_t state, next_state;
  logic [7:0] shift, next_shift;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic ack_drive, next_ack_drive;
  logic [6:0] next_channel_word, next_mode_word;
  logic next_channel_load, next_mode_load;
  logic [2:0] div_cnt, next_div_cnt;
  logic div_out, next_div_out, next_lock;
  logic [11:0] next_rf_ratio_x2;
  logic [10:0] next_if_ratio;
  // two-stage synchronisers for the link pins, then one stage for edges
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_m <= link.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= link.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s; // [R2]
  assign stop_ev = scl_s & scl_d & ~sda_d & sda_s; // [R3]
  always_comb
  begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_ack_drive = ack_drive;
    next_channel_word = channel_word;
    next_mode_word = mode_word;
    next_channel_load = 1'b0;
    next_mode_load = 1'b0;
    if (start_ev)
    begin
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_ack_drive = 1'b0;
    end
    else if (stop_ev)
    begin
      next_state = ST_IDLE; // [R3] [R7]
      next_ack_drive = 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE, ST_IGNORE:
        begin
          next_ack_drive = 1'b0; // [R17]
        end
        ST_ADDR, ST_DATA:
        begin
          if (scl_rise && bit_cnt != stp_pkg::LAST_BIT)
          begin
            next_shift = {shift[6:0], sda_s}; // [R1] [R4]
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == stp_pkg::LAST_BIT)
          begin
            if (state == ST_ADDR)
            begin
              if (shift == stp_pkg::ADDR_BYTE) // [R9]
              begin
                next_state = ST_ACK;
                next_ack_drive = 1'b1; // [R5]
              end
              else
              begin
                next_state = ST_IGNORE; // [R17]
              end
            end
            else
            begin
              next_state = ST_ACK;
              next_ack_drive = 1'b1; // [R5] [R18]
              if (shift[stp_pkg::SEL_BIT] == stp_pkg::SEL_CHANNEL) // [R10] [R11]
              begin
                next_channel_word = shift[6:0]; // [R12]
                next_channel_load = 1'b1;
              end
              else
              begin
                next_mode_word = shift[6:0]; // [R13]
                next_mode_load = 1'b1;
              end
            end
          end
        end
        ST_ACK:
        begin
          // hold low through the ninth pulse, release on its falling edge
          if (scl_fall)
          begin
            next_ack_drive = 1'b0; // [R6] [R8]
            next_state = ST_DATA;
            next_bit_cnt = 4'h0;
          end
        end
        default:
        begin
          next_state = ST_IDLE;
          next_ack_drive = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      ack_drive <= 1'b0;
      channel_word <= stp_pkg::CHANNEL_RESET;
      mode_word <= stp_pkg::MODE_RESET; // [R15]
      channel_load <= 1'b0;
      mode_load <= 1'b0;
    end
    else
    begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      ack_drive <= next_ack_drive;
      channel_word <= next_channel_word;
      mode_word <= next_mode_word;
      channel_load <= next_channel_load;
      mode_load <= next_mode_load;
    end
  end
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = ~ack_drive;
  // lock indicator: lock flags, a divided divider signal, or the undivided IF reference tick
  always_comb
  begin
    next_div_cnt = div_cnt;
    next_div_out = div_out;
    next_lock = 1'b0;
    next_rf_ratio_x2 = stp_pkg::RATIO_BASE_X2 + {5'h00, channel_word}; // [R14]
    next_if_ratio = stp_pkg::IF_RATIO_NOM;
    case (mode_word)
      stp_pkg::MODE_LOCK_RF: next_lock = rf_lock; // [R15]
      stp_pkg::MODE_LOCK_IF: next_lock = if_lock; // [R15]
      stp_pkg::MODE_LOCK_BOTH: next_lock = rf_lock & if_lock; // [R15]
      stp_pkg::MODE_DIV_RF_PROG:
      begin
        if (rf_prog_div_tick)
        begin
          next_div_cnt = (div_cnt == stp_pkg::TOG_LIM_16) ? 3'h0 : div_cnt + 3'h1; // [R16]
          next_div_out = (div_cnt == stp_pkg::TOG_LIM_16) ? ~div_out : div_out;
        end
        next_lock = div_out;
      end
      stp_pkg::MODE_DIV_RF_REF:
      begin
        if (rf_ref_div_tick)
        begin
          next_div_cnt = (div_cnt == stp_pkg::TOG_LIM_8) ? 3'h0 : div_cnt + 3'h1; // [R16]
          next_div_out = (div_cnt == stp_pkg::TOG_LIM_8) ? ~div_out : div_out;
        end
        next_lock = div_out;
      end
      stp_pkg::MODE_DIV_IF_FIX:
      begin
        if (if_fix_div_tick)
        begin
          next_div_cnt = stp_pkg::TOG_LIM_2; // [R16]
          next_div_out = ~div_out;
        end
        next_lock = div_out;
      end
      stp_pkg::MODE_DIV_IF_REF: next_lock = if_ref_div_tick; // [R16]
      stp_pkg::MODE_IF_LOW:
      begin
        next_if_ratio = stp_pkg::IF_RATIO_LOW;
        next_lock = if_lock;
      end
      stp_pkg::MODE_IF_HIGH:
      begin
        next_if_ratio = stp_pkg::IF_RATIO_HIGH;
        next_lock = if_lock;
      end
      default: next_lock = 1'b0;
    endcase
    // restart the divider whenever a new mode arrives
    if (mode_load)
    begin
      next_div_cnt = 3'h0;
      next_div_out = 1'b0;
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      div_cnt <= 3'h0;
      div_out <= 1'b0;
      lock_indicator_output <= 1'b0;
      rf_ratio_x2 <= stp_pkg::RATIO_BASE_X2;
      if_ratio <= stp_pkg::IF_RATIO_NOM;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      div_out <= next_div_out;
      lock_indicator_output <= next_lock;
      rf_ratio_x2 <= next_rf_ratio_x2;
      if_ratio <= next_if_ratio;
    end
  end
endmodule : stp_device

// ===== stp_pkg.sv
package stp_pkg;
  // device address on the bus and the write direction bit
  localparam logic [6:0] CHIP_ADDR = 7'h60;
  localparam logic WRITE_BIT = 1'b0;
  localparam logic [7:0] ADDR_BYTE = {CHIP_ADDR, WRITE_BIT};
  // bit layout of a data byte
  localparam int SEL_BIT = 7;
  localparam logic SEL_CHANNEL = 1'b1;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // startup settings
  localparam logic [6:0] CHANNEL_RESET = 7'h45;
  localparam logic [6:0] MODE_RESET = 7'h00;
  localparam logic [6:0] CHANNEL_LOWEST = 7'h06;
  // first loop ratio in half steps: 2 * 1440 + N
  localparam logic [11:0] RATIO_BASE_X2 = 12'hB40;
  // mode byte codes
  localparam logic [6:0] MODE_LOCK_RF = 7'h00;
  localparam logic [6:0] MODE_LOCK_IF = 7'h04;
  localparam logic [6:0] MODE_LOCK_BOTH = 7'h01;
  localparam logic [6:0] MODE_DIV_RF_PROG = 7'h12;
  localparam logic [6:0] MODE_DIV_RF_REF = 7'h1A;
  localparam logic [6:0] MODE_DIV_IF_FIX = 7'h16;
  localparam logic [6:0] MODE_DIV_IF_REF = 7'h1E;
  localparam logic [6:0] MODE_IF_LOW = 7'h40;
  localparam logic [6:0] MODE_IF_HIGH = 7'h60;
  // toggle limits: output divided by 2 * (limit + 1)
  localparam logic [2:0] TOG_LIM_16 = 3'h7;
  localparam logic [2:0] TOG_LIM_8 = 3'h3;
  localparam logic [2:0] TOG_LIM_2 = 3'h0;
  // second loop ratios
  localparam logic [10:0] IF_RATIO_NOM = 11'h40A;
  localparam logic [10:0] IF_RATIO_LOW = 11'h3DB;
  localparam logic [10:0] IF_RATIO_HIGH = 11'h439;
  // serial clock timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 400;
  localparam int SCL_HALF_CYC_I = SCL_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] SCL_HALF_CYC = SCL_HALF_CYC_I[3:0];
  localparam logic [3:0] SCL_HALF_LAST = SCL_HALF_CYC - 4'h1;
endpackage : stp_pkg

// ===== stp_if.sv
`timescale 1ns/1ps
interface stp_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;
  // open-drain data line with pull-up
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
endinterface : stp_if

// ===== stp_host.sv
`timescale 1ns/1ps
module stp_host (
  input wire logic core_clk,
  input wire logic rst,
  stp_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_two,
  input wire logic cmd_check_ack,
  input wire logic [7:0] cmd_byte0,
  input wire logic [7:0] cmd_byte1,
  output logic done,
  output logic nack
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_START = 6'b000010,
    H_LOW = 6'b000100,
    H_HIGH = 6'b001000,
    H_STOP_LOW = 6'b010000,
    H_STOP_HIGH = 6'b100000
  } stp_host_state_t;

  stp_host_state_t state;
  stp_host_state_t next_state;
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic tick;
  logic scl;
  logic next_scl;
  logic sda_low;
  logic next_sda_low;
  logic [1:0] byte_idx;
  logic [1:0] next_byte_idx;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic two;
  logic next_two;
  logic chk;
  logic next_chk;
  logic [7:0] b0;
  logic [7:0] next_b0;
  logic [7:0] b1;
  logic [7:0] next_b1;
  logic next_done;
  logic next_nack;
  logic sda_m;
  logic sda_s;
  logic [7:0] nxt_byte;
  logic last_byte;

  function automatic logic bit_of(input logic [7:0] v, input logic [3:0] i);
    bit_of = (i == stp_pkg::ACK_SLOT) ? 1'b1 : v[3'h7 - i[2:0]];
  endfunction : bit_of

  assign tick = (div_cnt == stp_pkg::SCL_HALF_LAST);
  assign cmd_ready = (state == H_IDLE) & tick;
  assign last_byte = two ? (byte_idx == 2'h2) : (byte_idx == 2'h1);
  assign nxt_byte = (byte_idx == 2'h0) ? b0 : b1;

  always_comb
  begin
    next_state = state;
    next_div_cnt = tick ? 4'h0 : div_cnt + 4'h1;
    next_scl = scl;
    next_sda_low = sda_low;
    next_byte_idx = byte_idx;
    next_bit_idx = bit_idx;
    next_two = two;
    next_chk = chk;
    next_b0 = b0;
    next_b1 = b1;
    next_done = 1'b0;
    next_nack = nack;
    case (state)
      H_IDLE:
      begin
        if (cmd_valid && cmd_ready)
        begin
          next_sda_low = 1'b1; // [R2]
          next_two = cmd_two; // [R9] [R11]
          next_chk = cmd_check_ack;
          next_b0 = cmd_byte0;
          next_b1 = cmd_byte1;
          next_nack = 1'b0;
          next_byte_idx = 2'h0;
          next_bit_idx = 4'h0;
          next_state = H_START;
        end
      end
      H_START:
      begin
        if (tick)
        begin
          next_scl = 1'b0;
          next_sda_low = ~bit_of(stp_pkg::ADDR_BYTE, 4'h0); // [R9]
          next_state = H_LOW;
        end
      end
      H_LOW:
      begin
        if (tick)
        begin
          next_scl = 1'b1;
          next_state = H_HIGH;
        end
      end
      H_HIGH:
      begin
        if (tick)
        begin
          next_scl = 1'b0; // [R1]
          if (bit_idx == stp_pkg::ACK_SLOT)
          begin
            if (sda_s)
            begin
              next_nack = 1'b1;
            end
            if ((sda_s && chk) || last_byte) // [R7] [R8]
            begin
              next_sda_low = 1'b1;
              next_state = H_STOP_LOW;
            end
            else
            begin
              next_byte_idx = byte_idx + 2'h1;
              next_bit_idx = 4'h0;
              next_sda_low = ~bit_of(nxt_byte, 4'h0);
              next_state = H_LOW;
            end
          end
          else
          begin
            next_bit_idx = bit_idx + 4'h1;
            next_sda_low = ~bit_of((byte_idx == 2'h0) ? stp_pkg::ADDR_BYTE :
                                   ((byte_idx == 2'h1) ? b0 : b1), bit_idx + 4'h1); // [R4] [R6]
            next_state = H_LOW;
          end
        end
      end
      H_STOP_LOW:
      begin
        if (tick)
        begin
          next_scl = 1'b1;
          next_state = H_STOP_HIGH;
        end
      end
      H_STOP_HIGH:
      begin
        if (tick)
        begin
          next_sda_low = 1'b0; // [R3]
          next_done = 1'b1;
          next_state = H_IDLE;
        end
      end
      default:
      begin
        next_state = H_IDLE;
        next_scl = 1'b1;
        next_sda_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= H_IDLE;
      div_cnt <= 4'h0;
      scl <= 1'b1;
      sda_low <= 1'b0;
      byte_idx <= 2'h0;
      bit_idx <= 4'h0;
      two <= 1'b0;
      chk <= 1'b0;
      b0 <= 8'h00;
      b1 <= 8'h00;
      done <= 1'b0;
      nack <= 1'b0;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end
    else
    begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      scl <= next_scl;
      sda_low <= next_sda_low;
      byte_idx <= next_byte_idx;
      bit_idx <= next_bit_idx;
      two <= next_two;
      chk <= next_chk;
      b0 <= next_b0;
      b1 <= next_b1;
      done <= next_done;
      nack <= next_nack;
      sda_m <= link.sda;
      sda_s <= sda_m;
    end
  end

  assign link.scl = scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = ~sda_low;
endmodule : stp_host

// ===== stp_chk.sv
`timescale 1ns/1ps
module stp_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  logic prev_scl, prev_sda, next_prev_scl, next_prev_sda, rise, start;
  logic [3:0] slot, next_slot;
  logic [1:0] nbyte, next_nbyte;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // bit slot within the current byte and byte index since the last start
  always_comb
  begin
    rise = scl & ~prev_scl;
    start = scl & prev_scl & prev_sda & ~sda;
    next_prev_scl = scl;
    next_prev_sda = sda;
    next_slot = slot;
    next_nbyte = nbyte;
    if (start)
    begin
      next_slot = 4'h0;
      next_nbyte = 2'h0;
    end
    else if (rise && slot == stp_pkg::ACK_SLOT)
    begin
      next_slot = 4'h0;
      if (nbyte != 2'h3)
        next_nbyte = nbyte + 2'h1;
    end
    else if (rise)
      next_slot = slot + 4'h1;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
      slot <= 4'h0;
      nbyte <= 2'h3;
    end
    else
    begin
      prev_scl <= next_prev_scl;
      prev_sda <= next_prev_sda;
      slot <= next_slot;
      nbyte <= next_nbyte;
    end
  end
  idle_released_a: assert property (disable iff (1'b0) $fell(rst) |-> scl && host_sda_oe_n && dev_sda_oe_n)
    else $error("bus not released after reset");
  start_then_low_a: assert property ($fell(sda) && scl && $past(scl) |->
    (!host_sda_oe_n && !host_sda_o) ##[3:5] !scl) else $error("start not followed by clock low");
  stop_holds_a: assert property ($rose(sda) && scl && $past(scl) |-> scl [*4])
    else $error("clock not idle after stop");
  data_hold_a: assert property ($rose(scl) |=> $stable(sda) [*3])
    else $error("data changed while clock high");
  msb_first_a: assert property (rise && nbyte == 2'h0 && slot < stp_pkg::ACK_SLOT |->
    sda == stp_pkg::ADDR_BYTE[3'h7 - slot[2:0]]) else $error("address bit wrong");
  host_release_a: assert property (rise && slot == stp_pkg::ACK_SLOT |-> host_sda_oe_n)
    else $error("host drives data in ack slot");
  dev_ack_a: assert property (rise && slot == stp_pkg::ACK_SLOT |->
    ##1 (!dev_sda_oe_n && !dev_sda_o) [*3] ##[1:7] dev_sda_oe_n) else $error("ack missing or stuck");
  ack_slot_only_a: assert property (!dev_sda_oe_n |-> slot == stp_pkg::ACK_SLOT || slot == 4'h0)
    else $error("device drives data outside ack");
endmodule : stp_chk

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_two = 1'b0;
  logic cmd_check_ack = 1'b1;
  logic [7:0] cmd_byte0 = 8'h00;
  logic [7:0] cmd_byte1 = 8'h00;
  logic rf_lock = 1'b0;
  logic if_lock = 1'b0;
  logic [3:0] ticks = 4'h0;
  logic cmd_ready, done, nack, channel_load, mode_load, lock_indicator_output;
  logic [6:0] channel_word, mode_word, ch_b;
  logic [11:0] rf_ratio_x2;
  logic [10:0] if_ratio;
  int miscompares = 0;
  int comparisons = 0;
  int ch_loads = 0;
  int md_loads = 0;
  stp_if link ();
  stp_if link_b ();
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (channel_load === 1'b1) ch_loads++;
  always @(posedge core_clk) if (mode_load === 1'b1) md_loads++;
  stp_host stp_host_inst (.core_clk(core_clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_two(cmd_two), .cmd_check_ack(cmd_check_ack), .cmd_byte0(cmd_byte0),
    .cmd_byte1(cmd_byte1), .done(done), .nack(nack));
  stp_device stp_device_inst (.core_clk(core_clk), .rst(rst), .link(link), .rf_lock(rf_lock),
    .if_lock(if_lock), .rf_prog_div_tick(ticks[0]), .rf_ref_div_tick(ticks[1]), .if_fix_div_tick(ticks[2]),
    .if_ref_div_tick(ticks[3]), .channel_word(channel_word), .mode_word(mode_word), .rf_ratio_x2(rf_ratio_x2),
    .if_ratio(if_ratio), .channel_load(channel_load), .mode_load(mode_load),
    .lock_indicator_output(lock_indicator_output));
  stp_device stp_device_inst_b (.core_clk(core_clk), .rst(rst), .link(link_b), .rf_lock(rf_lock),
    .if_lock(if_lock), .rf_prog_div_tick(ticks[0]), .rf_ref_div_tick(ticks[1]), .if_fix_div_tick(ticks[2]),
    .if_ref_div_tick(ticks[3]), .channel_word(ch_b), .mode_word(), .rf_ratio_x2(), .if_ratio(),
    .channel_load(), .mode_load(), .lock_indicator_output());
  stp_chk stp_chk_inst (.core_clk(core_clk), .rst(rst), .scl(link.scl), .host_sda_o(link.host_sda_o),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n),
    .sda(link.sda));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic send(input logic two, input logic chk, input logic [7:0] b0, input logic [7:0] b1);
    int n;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_two = two;
    cmd_check_ack = chk;
    cmd_byte0 = b0;
    cmd_byte1 = b1;
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 600)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("done", 32'(done), 32'h1);
  endtask : send
  // one half period of the hand-made serial clock, data released when d is high
  task automatic bb(input logic c, input logic d);
    @(posedge core_clk);
    #1;
    link_b.scl = c;
    link_b.host_sda_oe_n = d;
    repeat (3) @(posedge core_clk);
  endtask : bb
  task automatic bb_byte(input logic [7:0] b, input int n, output logic ack);
    for (int i = 0; i < n; i++)
    begin
      bb(1'b0, b[7 - i]);
      bb(1'b1, b[7 - i]);
    end
    if (n == 8)
    begin
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
    end
    #1;
    ack = link_b.sda;
  endtask : bb_byte
  task automatic bb_frame(input logic go);
    bb(1'b0, go);
    bb(1'b1, go);
    bb(1'b1, ~go);
    bb(1'b0, 1'b0);
  endtask : bb_frame
  task automatic t_reset();
    check("channel", 32'(channel_word), 32'(stp_pkg::CHANNEL_RESET));
    check("mode", 32'(mode_word), 32'h0);
    check("ratio", 32'(rf_ratio_x2), 32'd2880 + 32'(stp_pkg::CHANNEL_RESET));
    check("if ratio", 32'(if_ratio), 32'd1034);
  endtask : t_reset
  task automatic t_normal();
    int l;
    int m;
    l = ch_loads;
    m = md_loads;
    send(1'b1, 1'b1, 8'h86, 8'h04);
    check("channel", 32'(channel_word), 32'h06);
    check("mode", 32'(mode_word), 32'h04);
    check("ratio", 32'(rf_ratio_x2), 32'd2886);
    check("nack", 32'(nack), 32'h0);
    check("loads", 32'(ch_loads - l), 32'h1);
    check("mode loads", 32'(md_loads - m), 32'h1);
    send(1'b1, 1'b0, 8'h01, 8'hFF);
    check("mode", 32'(mode_word), 32'h01);
    check("channel", 32'(channel_word), 32'h7F);
    check("ratio", 32'(rf_ratio_x2), 32'd3007);
    send(1'b0, 1'b0, 8'h9D, 8'h00);
    check("channel", 32'(channel_word), 32'h1D);
  endtask : t_normal
  task automatic t_lock();
    logic [6:0] codes [5] = '{7'h00, 7'h04, 7'h01, 7'h40, 7'h60};
    logic e;
    logic [31:0] r;
    for (int k = 0; k < 5; k++)
    begin
      send(1'b0, 1'b1, {1'b0, codes[k]}, 8'h00);
      check("mode", 32'(mode_word), 32'(codes[k]));
      r = codes[k] == 7'h40 ? 32'd987 : (codes[k] == 7'h60 ? 32'd1081 : 32'd1034);
      check("if ratio", 32'(if_ratio), r);
      for (int j = 0; j < 2; j++)
      begin
        @(posedge core_clk);
        #1;
        rf_lock = ~j[0];
        if_lock = j[0];
        e = codes[k] == 7'h00 ? rf_lock : (codes[k] == 7'h01 ? rf_lock & if_lock : if_lock);
        repeat (2) @(posedge core_clk);
        #1;
        check("lock", 32'(lock_indicator_output), 32'(e));
      end
    end
  endtask : t_lock
  task automatic t_div();
    logic [6:0] codes [4] = '{7'h12, 7'h1A, 7'h16, 7'h1E};
    int nt [4] = '{16, 8, 2, 2};
    int tg [4] = '{2, 2, 2, 4};
    int seen;
    logic last;
    for (int k = 0; k < 4; k++)
    begin
      send(1'b0, 1'b1, {1'b0, codes[k]}, 8'h00);
      seen = 0;
      last = lock_indicator_output;
      for (int i = 0; i < 2 * nt[k] + 3; i++)
      begin
        @(posedge core_clk);
        #1;
        if (lock_indicator_output !== last)
          seen++;
        last = lock_indicator_output;
        ticks = (i % 2 == 0 && i < 2 * nt[k]) ? 4'(1 << k) : 4'h0;
      end
      check("toggles", 32'(seen), 32'(tg[k]));
    end
  endtask : t_div
  task automatic t_faults();
    logic a;
    bb_frame(1'b1);
    bb_byte(8'hC2, 8, a);
    check("foreign ack", 32'(a), 32'h1);
    bb_byte(8'h80, 8, a);
    check("foreign data ack", 32'(a), 32'h1);
    bb_frame(1'b0);
    check("foreign channel", 32'(ch_b), 32'(stp_pkg::CHANNEL_RESET));
    bb_frame(1'b1);
    bb_byte(8'hC0, 8, a);
    check("addr ack", 32'(a), 32'h0);
    bb_byte(8'h95, 4, a);
    bb_frame(1'b0);
    check("partial channel", 32'(ch_b), 32'(stp_pkg::CHANNEL_RESET));
    bb_frame(1'b1);
    bb_byte(8'hC0, 8, a);
    bb_byte(8'h91, 8, a);
    check("data ack", 32'(a), 32'h0);
    bb_frame(1'b0);
    check("single channel", 32'(ch_b), 32'h11);
  endtask : t_faults
  initial
  begin
    link_b.scl = 1'b1;
    link_b.host_sda_o = 1'b0;
    link_b.host_sda_oe_n = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    t_normal();
    t_lock();
    t_div();
    t_faults();
    close_out();
  end
  initial
  begin
    #1000000;
    miscompares++;
    close_out();
  end
endmodule : tb
